// ### design/brfa_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose : Constants and types for the banked register file addressing.
// Assumes : 8-bit register space of 256 locations, one core clock.
// Notes   : Shared by the design and by the verification side.
//////////////////////////////////////////////////////////////////////////////
package brfa_pkg;

  // Widths and depths
  localparam int BRFA_ADDR_W     = 8;
  localparam int BRFA_DATA_W     = 8;
  localparam int BRFA_SHORT_W    = 4;
  localparam int BRFA_EXP_DEPTH  = 16;
  localparam int BRFA_FILE_DEPTH = 256;

  // Bank 0 layout
  localparam logic [7:0] BRFA_PORT_LAST  = 8'h03;
  localparam logic [7:0] BRFA_GP_FIRST   = 8'h04;
  localparam logic [7:0] BRFA_GP_LAST    = 8'hEF;
  localparam logic [7:0] BRFA_CTRL_FIRST = 8'hF0;

  // Location of the working group pointer among the control registers
  localparam logic [7:0] BRFA_WGP_ADDR   = 8'hFD;

  // Part of the normal space that an expanded bank replaces
  localparam logic [7:0] BRFA_EXP_LAST   = 8'h0F;

  // Expanded bank selects (low nibble of the pointer)
  localparam logic [3:0] BRFA_BANK_D     = 4'hD;
  localparam logic [3:0] BRFA_BANK_F     = 4'hF;

  // Values after reset
  localparam logic [7:0] BRFA_WGP_RST    = 8'h00;
  localparam logic [7:0] BRFA_DATA_RST   = 8'h00;

  // Region a resolved location falls into
  typedef enum logic [1:0] {
    BRFA_REG_PORT = 2'b00,
    BRFA_REG_GP   = 2'b01,
    BRFA_REG_CTRL = 2'b10,
    BRFA_REG_EXP  = 2'b11
  } brfa_region_t;

  // Sequencer states, Gray along idle -> indirect -> idle
  typedef enum logic [1:0] {
    BRFA_ST_IDLE = 2'b00,
    BRFA_ST_IND  = 2'b01
  } brfa_state_t;

  // Request from the instruction datapath
  typedef struct packed {
    logic       write;
    logic       short_mode;
    logic       indirect;
    logic [7:0] addr;
    logic [7:0] wdata;
  } brfa_req_t;

  // Resolved target of an access
  typedef struct packed {
    brfa_region_t region;
    logic         bank_f;
    logic [7:0]   index;
  } brfa_tgt_t;

  // Answer to the instruction datapath
  typedef struct packed {
    brfa_region_t region;
    logic         bank_f;
    logic [7:0]   addr;
    logic [7:0]   rdata;
  } brfa_rsp_t;

endpackage

// ### design/brfa_top.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose : Register file with bank 0, expanded banks D and F, and the
//           working group pointer that steers short addressing.
// Assumes : Requests come from the core datapath on CLK_SYS; no sync.
// Notes   : Indirect access takes one extra cycle to fetch the pointer.
//
// Operation
// RULE1: Bank 0 holds ports 0-3, general 4-239, control 240-255.
// RULE2: Expanded banks D and F replace locations 00h-0Fh when selected.
// RULE3: Operands reached directly or indirectly through an 8-bit field.
// RULE4: Short mode splits the file into sixteen groups of sixteen.
// RULE5: Pointer gives the group start, 4-bit field picks the register.
// RULE6: Counter/timer registers sit in bank D; pointer 0Dh gives D, group 0.
// RULE7: Pointer 7Dh gives bank D while group 7 stays active.
// RULE8: Pointer high nibble picks the group, low nibble the bank.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps

module brfa_top
  import brfa_pkg::*;
#(
  parameter int DATA_W    = BRFA_DATA_W,
  parameter int EXP_DEPTH = BRFA_EXP_DEPTH
) (
  input  wire logic      CLK_SYS,
  input  wire logic      SRST,
  input  wire logic      REQ_VALID,
  input  wire brfa_req_t REQ,
  output logic           BUSY,
  output logic           RSP_VALID,
  output brfa_rsp_t      RSP,
  output logic [7:0]     WGP_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  ////////////////////////////////////////////////////////////////////////////

  // The packed carriers are fixed at eight data bits and sixteen entries
  if (DATA_W != BRFA_DATA_W) begin : g_bad_width
    $error("brfa_top: DATA_W must equal the carrier data width");
  end
  if (EXP_DEPTH != BRFA_EXP_DEPTH) begin : g_bad_depth
    $error("brfa_top: EXP_DEPTH must equal the replaced span");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  ////////////////////////////////////////////////////////////////////////////

  logic [7:0]  bank0_mem [0:BRFA_FILE_DEPTH-1];
  logic [7:0]  exp_d_mem [0:BRFA_EXP_DEPTH-1];
  logic [7:0]  exp_f_mem [0:BRFA_EXP_DEPTH-1];

  brfa_state_t state_ff;
  brfa_state_t nxt_state;
  logic [7:0]  wgp_ff;
  logic [7:0]  ptr_ff;
  brfa_req_t   held_ff;
  logic        busy_ff;
  logic        rsp_valid_ff;
  brfa_rsp_t   rsp_ff;

  brfa_tgt_t   acc_tgt;
  brfa_tgt_t   fetch_tgt;
  logic        acc_do;
  logic        acc_wr;
  logic [7:0]  acc_wdata;
  logic        take;

  ////////////////////////////////////////////////////////////////////////////
  // Address functions
  ////////////////////////////////////////////////////////////////////////////

  // Turn an instruction field into a location, short or full form
  function automatic brfa_tgt_t resolve(input logic [7:0] field,
                                        input logic       short_mode,
                                        input logic [7:0] wgp);
    brfa_tgt_t  t;
    logic [7:0] full;
    logic [3:0] bank;
    t    = '0;
    // RULE8: pointer nibble split
    bank = wgp[3:0];
    // RULE4: sixteen groups of sixteen
    // RULE5: group start plus 4-bit index
    full = short_mode ? {wgp[7:4], field[3:0]} : field;
    t.index = full;
    // RULE2: expanded bank overlays low span
    // RULE6: bank D select
    // RULE7: bank D with other group
    if (full <= BRFA_EXP_LAST &&
        (bank == BRFA_BANK_D || bank == BRFA_BANK_F)) begin
      t.region = BRFA_REG_EXP;
      t.bank_f = (bank == BRFA_BANK_F);
    // RULE1: bank 0 region split
    end else if (full <= BRFA_PORT_LAST) begin
      t.region = BRFA_REG_PORT;
    end else if (full <= BRFA_GP_LAST) begin
      t.region = BRFA_REG_GP;
    end else begin
      t.region = BRFA_REG_CTRL;
    end
    return t;
  endfunction

  // Read the byte at a resolved location
  function automatic logic [7:0] read_tgt(input brfa_tgt_t t,
                                          input logic [7:0] wgp);
    logic [7:0] v;
    v = BRFA_DATA_RST;
    if (t.region == BRFA_REG_EXP) begin
      v = t.bank_f ? exp_f_mem[t.index[3:0]] : exp_d_mem[t.index[3:0]];
    end else if (t.index == BRFA_WGP_ADDR) begin
      v = wgp;                       // Pointer reads back its own value
    end else begin
      v = bank0_mem[t.index];
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Access selection
  ////////////////////////////////////////////////////////////////////////////

  // Request accepted only while idle; busy requests are dropped
  assign take = REQ_VALID && (state_ff == BRFA_ST_IDLE);

  // Where the pointer byte of an indirect request is fetched from
  assign fetch_tgt = resolve(REQ.addr, REQ.short_mode, wgp_ff);

  // Pick this cycle's data access, direct or second indirect step
  always_comb begin
    acc_tgt   = '0;
    acc_do    = 1'b0;
    acc_wr    = 1'b0;
    acc_wdata = BRFA_DATA_RST;
    nxt_state = state_ff;
    case (state_ff)
      BRFA_ST_IDLE: begin
        // RULE3: direct or indirect operand
        if (take && !REQ.indirect) begin
          acc_tgt   = resolve(REQ.addr, REQ.short_mode, wgp_ff);
          acc_do    = 1'b1;
          acc_wr    = REQ.write;
          acc_wdata = REQ.wdata;
        end else if (take) begin
          nxt_state = BRFA_ST_IND;
        end
      end
      BRFA_ST_IND: begin
        // RULE3: fetched byte is a full address
        acc_tgt   = resolve(ptr_ff, 1'b0, wgp_ff);
        acc_do    = 1'b1;
        acc_wr    = held_ff.write;
        acc_wdata = held_ff.wdata;
        nxt_state = BRFA_ST_IDLE;
      end
      default: begin
        nxt_state = BRFA_ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  ////////////////////////////////////////////////////////////////////////////

  // State and busy flag
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      state_ff <= BRFA_ST_IDLE;
      busy_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      busy_ff  <= (nxt_state == BRFA_ST_IND);
    end
  end

  // Hold the indirect request and its fetched pointer byte
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      held_ff <= '0;
      ptr_ff  <= BRFA_DATA_RST;
    end else if (take && REQ.indirect) begin
      held_ff <= REQ;
      ptr_ff  <= read_tgt(fetch_tgt, wgp_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  ////////////////////////////////////////////////////////////////////////////

  // Working group pointer, written at its control location
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      wgp_ff <= BRFA_WGP_RST;
    // RULE8: pointer load steers group and bank
    end else if (acc_do && acc_wr && acc_tgt.region == BRFA_REG_CTRL &&
                 acc_tgt.index == BRFA_WGP_ADDR) begin
      wgp_ff <= acc_wdata;
    end
  end

  // Bank 0 storage, ports, general and control locations
  always_ff @(posedge CLK_SYS) begin
    // RULE1: bank 0 write
    if (acc_do && acc_wr && acc_tgt.region != BRFA_REG_EXP &&
        acc_tgt.index != BRFA_WGP_ADDR) begin
      bank0_mem[acc_tgt.index] <= acc_wdata;
    end
  end

  // Expanded banks; bank D holds the counter/timer registers
  always_ff @(posedge CLK_SYS) begin
    // RULE6: counter/timer bank D write
    if (acc_do && acc_wr && acc_tgt.region == BRFA_REG_EXP &&
        !acc_tgt.bank_f) begin
      exp_d_mem[acc_tgt.index[3:0]] <= acc_wdata;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    // RULE2: bank F write
    if (acc_do && acc_wr && acc_tgt.region == BRFA_REG_EXP &&
        acc_tgt.bank_f) begin
      exp_f_mem[acc_tgt.index[3:0]] <= acc_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Answer
  ////////////////////////////////////////////////////////////////////////////

  // One-cycle answer after each completed access; reads see old data
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      rsp_valid_ff <= 1'b0;
      rsp_ff       <= '0;
    end else begin
      rsp_valid_ff <= acc_do;
      if (acc_do) begin
        rsp_ff.region <= acc_tgt.region;
        rsp_ff.bank_f <= acc_tgt.bank_f;
        rsp_ff.addr   <= acc_tgt.index;
        rsp_ff.rdata  <= read_tgt(acc_tgt, wgp_ff);
      end
    end
  end

  // Outputs straight from flip-flops
  assign BUSY      = busy_ff;
  assign RSP_VALID = rsp_valid_ff;
  assign RSP       = rsp_ff;
  assign WGP_OUT   = wgp_ff;

endmodule

// ### tb/brfa_properties.sv
// Purpose : Port checks for the banked register file addressing.
// Assumes : Single clock, SRST synchronous and active high.
// Notes   : Bound to brfa_top from tb_top.
`timescale 1ns/100ps

module brfa_properties
  import brfa_pkg::*;
(
  input wire logic      CLK_SYS,
  input wire logic      SRST,
  input wire logic      REQ_VALID,
  input wire brfa_req_t REQ,
  input wire logic      BUSY,
  input wire logic      RSP_VALID,
  input wire brfa_rsp_t RSP,
  input wire logic [7:0] WGP_OUT
);
  // Region expected for a location under a given pointer
  function automatic brfa_region_t reg_of(input logic [7:0] a, w);
    if (a <= BRFA_EXP_LAST && (w[3:0] == BRFA_BANK_D ||
        w[3:0] == BRFA_BANK_F)) return BRFA_REG_EXP;
    if (a <= BRFA_PORT_LAST) return BRFA_REG_PORT;
    if (a <= BRFA_GP_LAST) return BRFA_REG_GP;
    return BRFA_REG_CTRL;
  endfunction

  // Taken requests and the location they resolve to
  wire       take = REQ_VALID && !BUSY;
  wire       dir  = take && !REQ.indirect;
  wire [7:0] loc  = REQ.short_mode ? {WGP_OUT[7:4], REQ.addr[3:0]}
                                   : REQ.addr;

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);

  a_direct_answer: assert property (dir |=> RSP_VALID)
    else $error("direct request not answered next cycle");
  a_indirect_seq: assert property (take && REQ.indirect |=>
    BUSY ##1 (!BUSY && RSP_VALID))
    else $error("indirect sequence timing wrong");
  a_answer_cause: assert property (RSP_VALID |->
    $past(take) || $past(BUSY)) else $error("answer without request");
  a_full_addr: assert property (dir && !REQ.short_mode |=>
    RSP.addr == $past(REQ.addr)) else $error("full address altered");
  a_short_loc: assert property (dir && REQ.short_mode |=>
    RSP.addr == {$past(WGP_OUT[7:4]), $past(REQ.addr[3:0])})
    else $error("short location wrong");
  a_region_map: assert property (dir |=>
    RSP.region == reg_of($past(loc), $past(WGP_OUT)))
    else $error("region wrong");
  a_bank_sel: assert property (dir && loc <= BRFA_EXP_LAST &&
    reg_of(loc, WGP_OUT) == BRFA_REG_EXP |=>
    RSP.bank_f == ($past(WGP_OUT[3:0]) == BRFA_BANK_F))
    else $error("expanded bank wrong");
  a_wgp_load: assert property (dir && REQ.write &&
    loc == BRFA_WGP_ADDR |=> WGP_OUT == $past(REQ.wdata))
    else $error("pointer not loaded");
  a_bank_d_zero: assert property (dir && WGP_OUT == 8'h0D &&
    REQ.short_mode && REQ.addr[3:0] == 4'h0 |=> RSP.region ==
    BRFA_REG_EXP && !RSP.bank_f && RSP.addr == 8'h00)
    else $error("pointer 0Dh did not give bank D entry 0");
  a_group_seven: assert property (dir && WGP_OUT == 8'h7D &&
    REQ.short_mode |=> RSP.region == BRFA_REG_GP && RSP.addr[7:4] == 4'h7)
    else $error("pointer 7Dh did not keep group 7");
  a_busy_drop: assert property (REQ_VALID && BUSY ##1 !take |=>
    !RSP_VALID) else $error("request taken while busy");

  // Main scenarios reached
  c_indirect: cover property (take && REQ.indirect ##2 RSP_VALID);
  c_bank_f: cover property (dir && loc <= 8'h0F && WGP_OUT == 8'h0F);
  c_group_seven: cover property (dir && WGP_OUT == 8'h7D);
  c_refused: cover property (REQ_VALID && BUSY);
endmodule

// ### tb/brfa_core_model.sv
// Purpose : Instruction datapath side that issues register requests.
// Assumes : One-cycle request pulse, launched after a rising edge.
// Notes   : Drops the request lines to inverted values when idle.
`timescale 1ns/100ps

module brfa_core_model
  import brfa_pkg::*;
(
  input wire logic CLK_SYS,
  output logic     REQ_VALID,
  output brfa_req_t REQ
);
  // Idle values at time zero
  initial begin
    REQ_VALID = 1'h0;
    REQ       = '0;
  end

  // One request, held for the single edge that takes it
  task automatic issue(input brfa_req_t r);
    @(posedge CLK_SYS);
    REQ_VALID <= 1'h1;
    REQ       <= r;
    @(posedge CLK_SYS);
    REQ_VALID <= 1'h0;
    REQ       <= ~r;
  endtask

  // Two requests on consecutive edges; returns at the edge taking the second
  task automatic pair(input brfa_req_t a, b);
    @(posedge CLK_SYS);
    REQ_VALID <= 1'h1;
    REQ       <= a;
    @(posedge CLK_SYS);
    REQ       <= b;
    @(posedge CLK_SYS);
    REQ_VALID <= 1'h0;
    REQ       <= ~b;
  endtask
endmodule

// ### tb/tb_top.sv
// Purpose : Self-checking bench for the register file addressing.
// Assumes : 40 MHz clock, reset held six cycles.
// Notes   : Every location is written before it is read back.
`timescale 1ns/100ps

module tb_top
  import brfa_pkg::*;
;
  logic       CLK_SYS = 1'h0;
  logic       SRST    = 1'h1;
  logic       REQ_VALID, BUSY, RSP_VALID, busy_seen;
  brfa_req_t  REQ;
  brfa_rsp_t  RSP, got;
  logic [7:0] WGP_OUT;
  int         err_total = 0;
  int         cmp_count = 0;

  always #12.5 CLK_SYS = ~CLK_SYS;

  brfa_core_model i_core (.CLK_SYS(CLK_SYS), .REQ_VALID(REQ_VALID),
                          .REQ(REQ));
  brfa_top i_dut (.CLK_SYS(CLK_SYS), .SRST(SRST), .REQ_VALID(REQ_VALID),
                  .REQ(REQ), .BUSY(BUSY), .RSP_VALID(RSP_VALID),
                  .RSP(RSP), .WGP_OUT(WGP_OUT));

  task automatic chk(input logic [18:0] g, e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // One access, answer awaited under a bound
  task automatic acc(input logic w, s, ind, input logic [7:0] a, d);
    int i;
    busy_seen = 1'h0;
    i_core.issue(brfa_req_t'{w, s, ind, a, d});
    for (i = 0; i < 4; i++) begin
      #1;
      if (BUSY === 1'h1) busy_seen = 1'h1;
      if (RSP_VALID === 1'h1) break;
      @(posedge CLK_SYS);
    end
    if (i == 4) begin
      err_total++;
      tally_and_finish();
    end
    got = RSP;
  endtask

  task automatic wgp(input logic [7:0] v);
    acc(1'h1, 1'h0, 1'h0, BRFA_WGP_ADDR, v);
    chk(WGP_OUT, v);
  endtask

  task automatic t_map;
    logic [7:0] am [6] = '{8'h00, 8'h03, 8'h04, 8'hEF, 8'hF0, 8'hFE};
    logic [1:0] rm [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
    wgp(8'h00);
    for (int i = 0; i < 6; i++) begin
      acc(1'h1, 1'h0, 1'h0, am[i], am[i] ^ 8'h5A);
      acc(1'h0, 1'h0, 1'h0, am[i], 8'h00);
      chk(got, {rm[i], 1'h0, am[i], am[i] ^ 8'h5A});
    end
    $display("bank zero map done");
  endtask

  task automatic t_short;
    wgp(8'hA3);
    acc(1'h1, 1'h1, 1'h0, 8'h07, 8'h3C);
    acc(1'h0, 1'h1, 1'h0, 8'hF7, 8'h00);
    chk(got, {2'h1, 1'h0, 8'hA7, 8'h3C});
    acc(1'h0, 1'h0, 1'h0, 8'hA7, 8'h00);
    chk(got, {2'h1, 1'h0, 8'hA7, 8'h3C});
    $display("short address done");
  endtask

  task automatic t_bank;
    wgp(8'h0D);
    acc(1'h1, 1'h1, 1'h0, 8'h00, 8'h55);
    acc(1'h1, 1'h0, 1'h0, 8'h02, 8'h66);
    acc(1'h0, 1'h0, 1'h0, 8'h00, 8'h00);
    chk(got, {2'h3, 1'h0, 8'h00, 8'h55});
    wgp(8'h0F);
    acc(1'h1, 1'h0, 1'h0, 8'h02, 8'h99);
    acc(1'h0, 1'h0, 1'h0, 8'h02, 8'h00);
    chk(got, {2'h3, 1'h1, 8'h02, 8'h99});
    wgp(8'h7D);
    acc(1'h1, 1'h1, 1'h0, 8'h01, 8'h11);
    acc(1'h0, 1'h0, 1'h0, 8'h71, 8'h00);
    chk(got, {2'h1, 1'h0, 8'h71, 8'h11});
    acc(1'h0, 1'h0, 1'h0, 8'h02, 8'h00);
    chk(got, {2'h3, 1'h0, 8'h02, 8'h66});
    $display("expanded banks done");
  endtask

  task automatic t_ind;
    wgp(8'h00);
    acc(1'h1, 1'h0, 1'h0, 8'h40, 8'h50);
    acc(1'h1, 1'h0, 1'h0, 8'h50, 8'h77);
    acc(1'h0, 1'h0, 1'h1, 8'h40, 8'h00);
    chk(got, {2'h1, 1'h0, 8'h50, 8'h77});
    chk(busy_seen, 1'h1);
    wgp(8'h40);
    acc(1'h0, 1'h1, 1'h1, 8'h00, 8'h00);
    chk(got, {2'h1, 1'h0, 8'h50, 8'h77});
    $display("indirect done");
  endtask

  // Back-to-back direct pair, then a request dropped while busy
  task automatic t_pair;
    wgp(8'h00);
    i_core.pair(brfa_req_t'{1'h1, 1'h0, 1'h0, 8'h60, 8'h12},
                brfa_req_t'{1'h0, 1'h0, 1'h0, 8'h60, 8'h00});
    #1;
    chk(RSP_VALID, 1'h1);
    chk(RSP, {2'h1, 1'h0, 8'h60, 8'h12});
    i_core.pair(brfa_req_t'{1'h0, 1'h0, 1'h1, 8'h40, 8'h00},
                brfa_req_t'{1'h1, 1'h0, 1'h0, BRFA_WGP_ADDR, 8'hEE});
    #1;
    chk(RSP_VALID, 1'h1);
    chk(RSP, {2'h1, 1'h0, 8'h50, 8'h77});
    @(posedge CLK_SYS);
    #1;
    chk(RSP_VALID, 1'h0);
    chk(WGP_OUT, 8'h00);
    $display("back to back done");
  endtask

  // Reset in mid-run clears the pointer and the answer
  task automatic t_reset;
    wgp(8'hB7);
    @(posedge CLK_SYS);
    SRST <= 1'h1;
    repeat (2) @(posedge CLK_SYS);
    SRST <= 1'h0;
    #1;
    chk(WGP_OUT, BRFA_WGP_RST);
    chk(RSP, 19'h0);
    chk({BUSY, RSP_VALID}, 2'h0);
    acc(1'h1, 1'h1, 1'h0, 8'h05, 8'h21);
    acc(1'h0, 1'h0, 1'h0, 8'h05, 8'h00);
    chk(got, {2'h1, 1'h0, 8'h05, 8'h21});
    $display("mid-run reset done");
  endtask

  // Reset, then the scenarios in turn
  initial begin
    repeat (6) @(posedge CLK_SYS);
    SRST <= 1'h0;
    t_map();
    t_short();
    t_bank();
    t_ind();
    t_pair();
    t_reset();
    tally_and_finish();
  end
endmodule

bind brfa_top brfa_properties i_props (.CLK_SYS(CLK_SYS), .SRST(SRST),
  .REQ_VALID(REQ_VALID), .REQ(REQ), .BUSY(BUSY), .RSP_VALID(RSP_VALID),
  .RSP(RSP), .WGP_OUT(WGP_OUT));
